/* logic/sai_pkg.sv */
// shared constants and types for the session attribute block
// assumes both ends and the link interface import nothing and use sai_pkg::name
`default_nettype none
package sai_pkg;
   localparam int NFLOW = 8;
   // session attribute types
   localparam logic [15:0] AVP_RESULT = 16'h0001;
   localparam logic [15:0] AVP_ALLOC_REQ = 16'h0002;
   localparam logic [15:0] AVP_ALLOC_REP = 16'h0003;
   localparam logic [15:0] AVP_LOCAL_MTU = 16'h0004;
   localparam logic [15:0] AVP_SYNC_CTL = 16'h0005;
   localparam logic [15:0] AVP_SESS_MAX = 16'h0063;
   localparam logic M_RESULT = 1'b0;
   localparam logic M_SET = 1'b1;
   // lengths in bytes
   localparam logic [9:0] LEN_RESULT = 10'h008;
   localparam logic [9:0] LEN_ERRCODE = 10'h002;
   localparam logic [9:0] LEN_REQ_BASE = 10'h006;
   localparam logic [9:0] LEN_REP_BASE = 10'h008;
   localparam logic [9:0] LEN_REP_PER = 10'h004;
   localparam logic [9:0] LEN_MTU = 10'h008;
   localparam logic [9:0] LEN_SYNC = 10'h00E;
   // codes
   localparam logic [15:0] SUB_TS = 16'h0003;
   localparam logic [15:0] SUB_PS = 16'h0004;
   localparam logic [15:0] PW_TS = 16'h000C;
   localparam logic [15:0] PW_PS = 16'h000D;
   localparam logic [15:0] SEQ_ALL = 16'h0002;
   localparam logic [15:0] RES_BAD_AVP = 16'h0000;
   localparam logic [15:0] RES_BAD_PHY = 16'h0001;
   localparam logic [15:0] RES_SEE_ERR = 16'h0002;
   localparam logic [15:0] ERR_NOT_READY = 16'h0000;
   localparam logic [15:0] ERR_LOCKED = 16'h0001;
   localparam logic [15:0] ERR_RANGE = 16'h0002;
   localparam logic [15:0] ERR_PHB = 16'h0003;
   localparam logic [15:0] ERR_PW = 16'h0004;
   // arbitrary neutral value
   localparam logic [31:0] VENDOR_ID_DEF = 32'h0000_0ABC;
   // sync interval
   localparam logic [14:0] IVAL_MIN = 15'h000A;
   localparam logic [14:0] IVAL_MAX = 15'h03E8;
   localparam int STEP_NS = 200000;
   localparam int CLK_NS = 8;
   localparam int STEP_CYC = STEP_NS / CLK_NS;
   // modulator registers and fields
   localparam logic [7:0] MR_CTRL = 8'h00;
   localparam logic [7:0] MR_MASK_LO = 8'h04;
   localparam logic [7:0] MR_MASK_HI = 8'h08;
   localparam logic [7:0] MR_UDP = 8'h0C;
   localparam logic [7:0] MR_TSOFF = 8'h10;
   localparam logic [7:0] MR_STAT = 8'h14;
   localparam int MC_READY = 0;
   localparam int MC_UDP = 1;
   localparam int MC_RF = 2;
   localparam logic [2:0] MCTRL_RST = 3'h0;
   localparam logic [63:0] MASK_RST = 64'h0;
   // core registers and fields
   localparam logic [7:0] CR_CTRL = 8'h00;
   localparam logic [7:0] CR_PHB0 = 8'h04;
   localparam logic [7:0] CR_PHB1 = 8'h08;
   localparam logic [7:0] CR_SYNC = 8'h0C;
   localparam logic [7:0] CR_MAC_LO = 8'h10;
   localparam logic [7:0] CR_MAC_HI = 8'h14;
   localparam logic [7:0] CR_MTU = 8'h18;
   localparam logic [7:0] CR_STAT = 8'h1C;
   localparam logic [7:0] CR_UDP0 = 8'h20;
   localparam int CC_ICRQ = 0;
   localparam int CC_ICCN = 1;
   localparam int CC_SLI = 2;
   localparam int CC_PS = 3;
   localparam int CC_UDP = 4;
   localparam int CC_NEW = 5;
   localparam int CC_UP = 6;
   localparam int CC_NF = 8;
   localparam int SY_EN = 31;
   localparam logic [15:0] MTU_RST = 16'h05DC;
   typedef enum logic [2:0] {MSG_ICRQ, MSG_ICRP, MSG_ICCN, MSG_CDN, MSG_SLI} sai_msg_t;
endpackage
`default_nettype wire

/* logic/sai_link_if.sv */
// session signalling link between headend core and edge modulator
// assumes both ends run on one pclk; no clocking here
`default_nettype none
interface sai_link_if;
   logic req_valid;
   sai_pkg::sai_msg_t req_msg;
   logic [15:0] req_pw;
   logic [15:0] req_sub;
   logic [9:0] req_len;
   logic [3:0] req_nflows;
   logic [sai_pkg::NFLOW-1:0][5:0] req_phb;
   logic req_new;
   logic req_active;
   logic [15:0] req_mtu;
   logic sync_en;
   logic [14:0] sync_ival;
   logic [47:0] sync_mac;
   logic rep_valid;
   sai_pkg::sai_msg_t rep_msg;
   logic [15:0] rep_type;
   logic rep_m;
   logic [9:0] rep_len;
   logic [15:0] rep_sub;
   logic [15:0] rep_seq;
   logic [3:0] rep_nflows;
   logic [sai_pkg::NFLOW-1:0][5:0] rep_phb;
   logic [sai_pkg::NFLOW-1:0][2:0] rep_fid;
   logic [sai_pkg::NFLOW-1:0][15:0] rep_udp;
   logic [15:0] rep_result;
   logic [15:0] rep_error;
   logic [31:0] rep_vendor;
   logic rep_new;
   logic rep_active;
   logic data_valid;
   logic [7:0] data;
   logic ts_valid;
   logic [31:0] ts;
   modport core (output req_valid, req_msg, req_pw, req_sub, req_len, req_nflows, req_phb,
      req_new, req_active, req_mtu, sync_en, sync_ival, sync_mac, data_valid, data,
      ts_valid, ts, input rep_valid, rep_msg, rep_type, rep_m, rep_len, rep_sub, rep_seq,
      rep_nflows, rep_phb, rep_fid, rep_udp, rep_result, rep_error, rep_vendor, rep_new,
      rep_active);
   modport modulator (input req_valid, req_msg, req_pw, req_sub, req_len, req_nflows,
      req_phb, req_new, req_active, req_mtu, sync_en, sync_ival, sync_mac, data_valid, data,
      ts_valid, ts, output rep_valid, rep_msg, rep_type, rep_m, rep_len, rep_sub, rep_seq,
      rep_nflows, rep_phb, rep_fid, rep_udp, rep_result, rep_error, rep_vendor, rep_new,
      rep_active);
endinterface
`default_nettype wire

/* logic/sai_sync_timer.sv */
// interval timer for generated sync messages
// assumes ival already clamped to the supported range
`default_nettype none
module sai_sync_timer #(
   parameter int STEP_CYC = sai_pkg::STEP_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic restart,
   input wire logic [14:0] ival,
   output logic tick
);
   localparam int CW = $clog2(STEP_CYC + 1);
   typedef struct packed {
      logic [CW-1:0] cyc;
      logic [14:0] steps;
   } sai_tmr_t;
   sai_tmr_t r, n;
   logic wrap, done;
   always_comb begin
      n = r;
      wrap = (r.cyc == CW'(STEP_CYC - 1));
      done = wrap && (r.steps == ival - 15'h0001);
      tick = run && done;
      // idle or restarted timer starts a whole interval afresh
      if (!run || restart) begin
         n = '0;
      end else if (wrap) begin
         n.cyc = '0;
         n.steps = done ? 15'h0000 : r.steps + 15'h0001;
      end else begin
         n.cyc = r.cyc + CW'(1);
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
endmodule // sai_sync_timer
`default_nettype wire

/* logic/sai_modulator.sv */
// edge modulator end: answers session setup, handles sync messages
// assumes APB master on pclk; headend core on the link waits for each reply
//
// Register access over APB and the address map are this design's own decisions.
`default_nettype none
module sai_modulator #(
   parameter int STEP_CYC = sai_pkg::STEP_CYC,
   parameter logic [31:0] VENDOR_ID = sai_pkg::VENDOR_ID_DEF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   sai_link_if.modulator lk,
   output logic sync_valid,
   output logic [31:0] sync_ts,
   output logic [47:0] sync_mac,
   output logic stream_valid,
   output logic [7:0] stream_data,
   output logic rf_on,
   output logic sess_up
);
   localparam int NF = sai_pkg::NFLOW;
   typedef enum logic [1:0] {M_IDLE, M_SCAN, M_REPLY} sai_mst_t;
   typedef struct packed {
      sai_mst_t st;
      logic [3:0] idx;
      logic [3:0] cnt;
      logic ps;
      logic up;
      logic fresh;
      logic fail;
      logic [15:0] res;
      logic [15:0] err;
      logic [3:0] qn;
      logic [NF-1:0][5:0] qphb;
      logic sen;
      logic [14:0] ival;
      logic [47:0] mac;
      logic [2:0] ctrl;
      logic [63:0] mask;
      logic [15:0] udp;
      logic [31:0] tsoff;
      logic [31:0] tsc;
      logic rv;
      sai_pkg::sai_msg_t rmsg;
      logic [15:0] rtype;
      logic rm;
      logic [9:0] rlen;
      logic [NF-1:0][5:0] rphb;
      logic [NF-1:0][2:0] rfid;
      logic [NF-1:0][15:0] rudp;
      logic sv;
      logic [31:0] sts;
      logic [47:0] smac;
      logic dv;
      logic [7:0] dat;
   } sai_mod_t;
   sai_mod_t r, n;
   logic wr, rd_ok, tick, prov;
   logic [14:0] ival_eff;
   logic [5:0] cur;

   // out-of-range intervals are clamped rather than refused
   assign ival_eff = (r.ival < sai_pkg::IVAL_MIN) ? sai_pkg::IVAL_MIN :
                     (r.ival > sai_pkg::IVAL_MAX) ? sai_pkg::IVAL_MAX : r.ival;

   // the timer restarts itself on every tick it emits
   sai_sync_timer #(.STEP_CYC(STEP_CYC)) u_tmr (
      .pclk(pclk),
      .presetn(presetn),
      .run(r.ps && r.sen),
      .restart(tick),
      .ival(ival_eff),
      .tick(tick)
   );

   assign wr = psel && penable && pwrite;
   // provisioning outranks a reply that clears the new flag in the same cycle
   assign prov = wr && paddr == sai_pkg::MR_CTRL && pwdata[sai_pkg::MC_READY]
                 && !r.ctrl[sai_pkg::MC_READY];
   assign cur = r.qphb[r.idx[2:0]];
   assign pready = 1'b1;
   always_comb begin
      rd_ok = 1'b1;
      prdata = '0;
      unique case (paddr)
         sai_pkg::MR_CTRL: prdata = {29'h0, r.ctrl};
         sai_pkg::MR_MASK_LO: prdata = r.mask[31:0];
         sai_pkg::MR_MASK_HI: prdata = r.mask[63:32];
         sai_pkg::MR_UDP: prdata = {16'h0, r.udp};
         sai_pkg::MR_TSOFF: prdata = r.tsoff;
         sai_pkg::MR_STAT: prdata = {r.err, 4'h0, r.cnt, 4'h0, r.fresh, r.sen, r.ps, r.up};
         default: rd_ok = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !rd_ok;

   always_comb begin
      n = r;
      n.rv = 1'b0;
      n.sv = 1'b0;
      n.tsc = r.tsc + 32'h1;
      n.dv = lk.data_valid;
      n.dat = lk.data;
      if (wr) begin
         unique case (paddr)
            sai_pkg::MR_CTRL: begin
               n.ctrl = pwdata[2:0];
               // provisioning: ready rising marks the next session as new
               if (prov) n.fresh = 1'b1;
               if (!pwdata[sai_pkg::MC_READY]) n.up = 1'b0;
            end
            sai_pkg::MR_MASK_LO: n.mask[31:0] = pwdata;
            sai_pkg::MR_MASK_HI: n.mask[63:32] = pwdata;
            sai_pkg::MR_UDP: n.udp = pwdata[15:0];
            sai_pkg::MR_TSOFF: n.tsoff = pwdata;
            default: ;
         endcase
      end
      unique case (r.st)
         M_IDLE: begin
            if (lk.req_valid && lk.req_msg == sai_pkg::MSG_ICRQ) begin
               n.ps = (lk.req_pw == sai_pkg::PW_PS);
               n.qn = lk.req_nflows;
               n.qphb = lk.req_phb;
               n.sen = lk.sync_en;
               n.ival = lk.sync_ival;
               n.mac = lk.sync_mac;
               n.up = 1'b0;
               n.idx = '0;
               n.cnt = '0;
               n.rphb = '0;
               n.rfid = '0;
               n.rudp = '0;
               n.fail = 1'b1;
               n.res = sai_pkg::RES_SEE_ERR;
               n.err = sai_pkg::ERR_NOT_READY;
               if (!r.ctrl[sai_pkg::MC_READY]) begin
                  n.st = M_REPLY;
               end else if (lk.req_pw != sai_pkg::PW_TS && lk.req_pw != sai_pkg::PW_PS) begin
                  n.err = sai_pkg::ERR_PW;
                  n.st = M_REPLY;
               end else if (lk.req_sub != ((lk.req_pw == sai_pkg::PW_PS) ?
                            sai_pkg::SUB_PS : sai_pkg::SUB_TS)) begin
                  n.res = sai_pkg::RES_BAD_AVP;
                  n.st = M_REPLY;
               end else if (lk.req_pw == sai_pkg::PW_TS && lk.req_nflows != 4'h1) begin
                  n.res = sai_pkg::RES_BAD_AVP;
                  n.st = M_REPLY;
               end else begin
                  n.fail = 1'b0;
                  n.st = M_SCAN;
               end
            end else if (lk.req_valid && lk.req_msg == sai_pkg::MSG_ICCN) begin
               n.up = lk.req_active && !r.fail && r.cnt != 4'h0 && r.ctrl[sai_pkg::MC_READY];
            end else if (lk.req_valid && lk.req_msg == sai_pkg::MSG_SLI) begin
               n.sen = lk.sync_en;
               n.ival = lk.sync_ival;
               n.mac = lk.sync_mac;
               if (!lk.req_active) n.up = 1'b0;
            end
         end
         M_SCAN: begin
            // unsupported ids are skipped; kept ones pack down in request order
            if (r.idx < r.qn && r.mask[cur]) begin
               n.rphb[r.cnt[2:0]] = cur;
               n.rfid[r.cnt[2:0]] = r.cnt[2:0];
               n.rudp[r.cnt[2:0]] = r.ctrl[sai_pkg::MC_UDP] ?
                                    r.udp + {12'h0, r.cnt} : 16'h0;
               n.cnt = r.cnt + 4'h1;
            end
            if (r.idx == 4'(NF - 1)) n.st = M_REPLY;
            else n.idx = r.idx + 4'h1;
         end
         M_REPLY: begin
            n.rv = 1'b1;
            n.st = M_IDLE;
            if (r.fail || r.cnt == 4'h0) begin
               n.fail = 1'b1;
               if (!r.fail) n.err = sai_pkg::ERR_PHB;
               n.rmsg = sai_pkg::MSG_CDN;
               n.rtype = sai_pkg::AVP_RESULT;
               n.rm = sai_pkg::M_RESULT;
               n.rlen = sai_pkg::LEN_RESULT + sai_pkg::LEN_ERRCODE;
            end else begin
               n.rmsg = sai_pkg::MSG_ICRP;
               n.rtype = sai_pkg::AVP_ALLOC_REP;
               n.rm = sai_pkg::M_SET;
               n.rlen = sai_pkg::LEN_REP_BASE + 10'(r.cnt) * sai_pkg::LEN_REP_PER;
               if (!prov) n.fresh = 1'b0;
            end
         end
         default: n.st = M_IDLE;
      endcase
      // sync handling never depends on circuit status or RF state
      if (r.ps) begin
         if (tick) begin
            n.sv = 1'b1;
            n.sts = r.tsc;
            n.smac = r.mac;
         end
      end else if (lk.ts_valid) begin
         n.sv = 1'b1;
         n.sts = r.sen ? lk.ts + r.tsoff : lk.ts;
         n.smac = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.st <= M_IDLE;
         r.fresh <= 1'b1;
         r.ctrl <= sai_pkg::MCTRL_RST;
         r.mask <= sai_pkg::MASK_RST;
      end else begin
         r <= n;
      end
   end

   assign lk.rep_valid = r.rv;
   assign lk.rep_msg = r.rmsg;
   assign lk.rep_type = r.rtype;
   assign lk.rep_m = r.rm;
   assign lk.rep_len = r.rlen;
   assign lk.rep_sub = r.ps ? sai_pkg::SUB_PS : sai_pkg::SUB_TS;
   assign lk.rep_seq = sai_pkg::SEQ_ALL;
   assign lk.rep_nflows = r.cnt;
   assign lk.rep_phb = r.rphb;
   assign lk.rep_fid = r.rfid;
   assign lk.rep_udp = r.rudp;
   assign lk.rep_result = r.res;
   assign lk.rep_error = r.err;
   assign lk.rep_vendor = VENDOR_ID;
   assign lk.rep_new = r.fresh;
   assign lk.rep_active = r.ctrl[sai_pkg::MC_READY] && !r.fail;
   assign sync_valid = r.sv;
   assign sync_ts = r.sts;
   assign sync_mac = r.smac;
   assign stream_valid = r.dv;
   assign stream_data = r.dat;
   assign rf_on = r.ctrl[sai_pkg::MC_RF];
   assign sess_up = r.up;
endmodule // sai_modulator
`default_nettype wire

/* logic/sai_core.sv */
// headend core end: issues session requests from software registers
// assumes APB master on pclk; one request outstanding at a time
`default_nettype none
module sai_core (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   sai_link_if.core lk,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   input wire logic ts_in_valid,
   input wire logic [31:0] ts_in
);
   localparam int NF = sai_pkg::NFLOW;
   typedef struct packed {
      logic [15:0] cfg;
      logic [NF-1:0][5:0] phb;
      logic sen;
      logic [14:0] ival;
      logic [47:0] mac;
      logic [15:0] mtu;
      logic rv;
      sai_pkg::sai_msg_t msg;
      logic up;
      logic got;
      logic cdn;
      logic [15:0] err;
      logic [3:0] gnt;
      logic [15:0] udp0;
      logic dv;
      logic [7:0] dat;
      logic tv;
      logic [31:0] ts;
   } sai_core_t;
   sai_core_t r, n;
   logic wr, rd_ok, ps;
   logic [3:0] nf;

   assign wr = psel && penable && pwrite;
   assign ps = r.cfg[sai_pkg::CC_PS];
   assign nf = ps ? r.cfg[sai_pkg::CC_NF +: 4] : 4'h1;
   assign pready = 1'b1;
   always_comb begin
      rd_ok = 1'b1;
      prdata = '0;
      unique case (paddr)
         sai_pkg::CR_CTRL: prdata = {16'h0, r.cfg};
         sai_pkg::CR_SYNC: prdata = {r.sen, 16'h0, r.ival};
         sai_pkg::CR_MAC_LO: prdata = r.mac[31:0];
         sai_pkg::CR_MAC_HI: prdata = {16'h0, r.mac[47:32]};
         sai_pkg::CR_MTU: prdata = {16'h0, r.mtu};
         sai_pkg::CR_STAT: prdata = {r.err, 4'h0, r.gnt, 5'h0, r.cdn, r.got, r.up};
         sai_pkg::CR_UDP0: prdata = {16'h0, r.udp0};
         default: rd_ok = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !rd_ok;

   always_comb begin
      n = r;
      n.rv = 1'b0;
      // data only flows while the session is up
      n.dv = r.up && tx_valid;
      n.dat = tx_data;
      n.tv = !ps && ts_in_valid;
      n.ts = ts_in;
      if (wr) begin
         unique case (paddr)
            sai_pkg::CR_CTRL: begin
               n.cfg = pwdata[15:0];
               n.rv = |pwdata[2:0];
               if (pwdata[sai_pkg::CC_ICRQ]) begin
                  n.msg = sai_pkg::MSG_ICRQ;
                  n.got = 1'b0;
                  n.cdn = 1'b0;
                  n.up = 1'b0;
               end else if (pwdata[sai_pkg::CC_ICCN]) begin
                  n.msg = sai_pkg::MSG_ICCN;
                  n.up = r.got && pwdata[sai_pkg::CC_UP];
               end else begin
                  n.msg = sai_pkg::MSG_SLI;
                  if (!pwdata[sai_pkg::CC_UP]) n.up = 1'b0;
               end
            end
            sai_pkg::CR_PHB0, sai_pkg::CR_PHB1: begin
               for (int j = 0; j < 4; j++) begin
                  n.phb[(paddr == sai_pkg::CR_PHB1 ? 4 : 0) + j] = pwdata[8*j +: 6];
               end
            end
            sai_pkg::CR_SYNC: begin
               n.sen = pwdata[sai_pkg::SY_EN];
               n.ival = pwdata[14:0];
            end
            sai_pkg::CR_MAC_LO: n.mac[31:0] = pwdata;
            sai_pkg::CR_MAC_HI: n.mac[47:32] = pwdata[15:0];
            sai_pkg::CR_MTU: n.mtu = pwdata[15:0];
            default: ;
         endcase
      end
      if (lk.rep_valid) begin
         if (lk.rep_msg == sai_pkg::MSG_CDN) begin
            n.cdn = 1'b1;
            n.up = 1'b0;
            n.err = lk.rep_error;
         end else begin
            n.got = lk.rep_sub == (ps ? sai_pkg::SUB_PS : sai_pkg::SUB_TS);
            n.gnt = lk.rep_nflows;
            // the port is meaningless without udp encapsulation
            n.udp0 = r.cfg[sai_pkg::CC_UDP] ? lk.rep_udp[0] : 16'h0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.mtu <= sai_pkg::MTU_RST;
      end else begin
         r <= n;
      end
   end

   assign lk.req_valid = r.rv;
   assign lk.req_msg = r.msg;
   assign lk.req_pw = ps ? sai_pkg::PW_PS : sai_pkg::PW_TS;
   assign lk.req_sub = ps ? sai_pkg::SUB_PS : sai_pkg::SUB_TS;
   assign lk.req_len = sai_pkg::LEN_REQ_BASE + {6'h0, nf};
   assign lk.req_nflows = nf;
   assign lk.req_phb = r.phb;
   assign lk.req_new = r.cfg[sai_pkg::CC_NEW];
   assign lk.req_active = r.cfg[sai_pkg::CC_UP];
   assign lk.req_mtu = r.mtu;
   assign lk.sync_en = r.sen;
   assign lk.sync_ival = ps ? r.ival : 15'h0;
   assign lk.sync_mac = r.mac;
   assign lk.data_valid = r.dv;
   assign lk.data = r.dat;
   assign lk.ts_valid = r.tv;
   assign lk.ts = r.ts;
   assign tx_ready = r.up;
endmodule // sai_core
`default_nettype wire

/* dv/sai_properties.sv */
// link checker for the core and modulator ends
// assumes instantiation beside the link interface in the bench top
`default_nettype none
module sai_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic req_valid,
   input var sai_pkg::sai_msg_t req_msg,
   input wire logic [15:0] req_pw,
   input wire logic [15:0] req_sub,
   input wire logic [9:0] req_len,
   input wire logic [3:0] req_nflows,
   input wire logic rep_valid,
   input var sai_pkg::sai_msg_t rep_msg,
   input wire logic [15:0] rep_type,
   input wire logic rep_m,
   input wire logic [9:0] rep_len,
   input wire logic [15:0] rep_sub,
   input wire logic [15:0] rep_seq,
   input wire logic [3:0] rep_nflows,
   input wire logic [31:0] rep_vendor
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic rq, ok, cdn;
   assign rq = req_valid && req_msg == sai_pkg::MSG_ICRQ;
   assign ok = rep_valid && rep_msg == sai_pkg::MSG_ICRP;
   assign cdn = rep_valid && rep_msg == sai_pkg::MSG_CDN;
   property p_lat; rq |-> ##[2:10] rep_valid; endproperty
   a_lat: assert property (p_lat) else $error("request left unanswered");
   property p_sub; rq ##10 ok |-> rep_sub == $past(req_sub, 10); endproperty
   a_sub: assert property (p_sub) else $error("reply sublayer differs");
   property p_seq; ok |-> rep_seq == sai_pkg::SEQ_ALL; endproperty
   a_seq: assert property (p_seq) else $error("sequencing level wrong");
   property p_res; cdn |-> rep_type == sai_pkg::AVP_RESULT && rep_m == sai_pkg::M_RESULT
      && rep_len >= sai_pkg::LEN_RESULT; endproperty
   a_res: assert property (p_res) else $error("result header wrong");
   property p_ven; cdn |-> rep_vendor != 32'h0000_0000; endproperty
   a_ven: assert property (p_ven) else $error("vendor field zero");
   property p_rep; ok |-> rep_type == sai_pkg::AVP_ALLOC_REP && rep_m
      && rep_len == sai_pkg::LEN_REP_BASE + sai_pkg::LEN_REP_PER * rep_nflows; endproperty
   a_rep: assert property (p_rep) else $error("reply header wrong");
   property p_req; rq |-> req_len == sai_pkg::LEN_REQ_BASE + req_nflows; endproperty
   a_req: assert property (p_req) else $error("request length wrong");
   property p_ts; rq && req_pw == sai_pkg::PW_TS |-> req_nflows == 4'h1
      && req_sub == sai_pkg::SUB_TS; endproperty
   a_ts: assert property (p_ts) else $error("stream request malformed");
   property p_sl; rq |-> req_sub == (req_pw == sai_pkg::PW_PS ? sai_pkg::SUB_PS
      : sai_pkg::SUB_TS); endproperty
   a_sl: assert property (p_sl) else $error("request sublayer differs");
   c_ok: cover property (ok);
   c_cdn: cover property (cdn);
   c_ts: cover property (rq && req_pw == sai_pkg::PW_TS);
endmodule // sai_properties
`default_nettype wire

/* dv/session_avp_and_sync_insertion_tb_top.sv */
// bench top: both ends joined by the link, each with its own apb port
// assumes zero-wait apb slaves; replies and data checked from queues
`default_nettype none
module session_avp_and_sync_insertion_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel_m = 0, psel_c = 0, penable = 0, pwrite = 0;
   logic tx_valid = 0, rdy_m, rdy_c, err_m, err_c, sv, rf_on, sess_up, e, sy, tx_rdy, ts_v = 0;
   logic [47:0] sm;
   logic [7:0] paddr = 8'h00, tx_data = 8'h00, sd, r;
   logic [31:0] pwdata = 32'h0, prd_m, prd_c, rd, st, ts_i = 32'h0;
   logic [44:0] q[$], sq[$];
   logic [7:0] dq[$];
   int n_mismatch = 0, check_count = 0, seed = 40474, nw = 0;
   always #4 pclk = ~pclk;
   sai_link_if lk ();
   sai_modulator #(.STEP_CYC(4)) sai_modulator_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel_m), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prd_m), .pready(rdy_m), .pslverr(err_m), .lk(lk), .sync_valid(sy), .sync_ts(st),
      .sync_mac(sm), .stream_valid(sv), .stream_data(sd), .rf_on(rf_on), .sess_up(sess_up));
   sai_core sai_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel_c), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prd_c), .pready(rdy_c),
      .pslverr(err_c), .lk(lk), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_rdy),
      .ts_in_valid(ts_v), .ts_in(ts_i));
   sai_properties sai_properties_inst (.pclk(pclk), .presetn(presetn),
      .req_valid(lk.req_valid), .req_msg(lk.req_msg), .req_pw(lk.req_pw),
      .req_sub(lk.req_sub), .req_len(lk.req_len), .req_nflows(lk.req_nflows),
      .rep_valid(lk.rep_valid), .rep_msg(lk.rep_msg), .rep_type(lk.rep_type),
      .rep_m(lk.rep_m), .rep_len(lk.rep_len), .rep_sub(lk.rep_sub), .rep_seq(lk.rep_seq),
      .rep_nflows(lk.rep_nflows), .rep_vendor(lk.rep_vendor));
   task chk(input logic [44:0] s, input logic [44:0] x);
      check_count++;
      if (s !== x) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, s, x);
      end
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // bounded wait; a hang counts against the run
   task automatic wt(ref logic s, input logic v);
      int n;
      n = 0;
      while (s !== v && n < 60) begin
         @(posedge pclk);
         n++;
      end
      nw = n;
      if (s !== v) begin
         n_mismatch++;
         end_sim();
      end
   endtask
   task apb(input logic m, input logic [7:0] a, input logic [31:0] d, input logic w);
      @(posedge pclk);
      psel_m <= m;
      psel_c <= !m;
      paddr <= a;
      pwdata <= d;
      pwrite <= w;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      if (m) wt(rdy_m, 1'b1);
      else wt(rdy_c, 1'b1);
      rd = m ? prd_m : prd_c;
      e = m ? err_m : err_c;
      psel_m <= 1'b0;
      psel_c <= 1'b0;
      penable <= 1'b0;
   endtask
   task req(input logic [31:0] c, input logic [31:0] p, input logic [44:0] x);
      apb(1'b0, sai_pkg::CR_PHB0, p, 1'b1);
      q.push_back(x);
      apb(1'b0, sai_pkg::CR_CTRL, c, 1'b1);
      wt(lk.rep_valid, 1'b1);
      $display("request test done");
   endtask
   // one passing sync timestamp; o is the correction expected on it
   task tsp(input logic [31:0] o);
      @(posedge pclk);
      ts_v <= 1'b1;
      ts_i <= $random(seed);
      @(posedge pclk);
      sq.push_back({13'h0, ts_i + o});
      ts_v <= 1'b0;
   endtask
   always @(posedge pclk) begin
      logic [15:0] v;
      v = lk.rep_msg == sai_pkg::MSG_ICRP ? {6'h00, lk.rep_nflows, lk.rep_phb[0]}
         : {lk.rep_result[7:0], lk.rep_error[7:0]};
      if (lk.rep_valid === 1'b1)
         chk({lk.rep_msg, lk.rep_type, lk.rep_len, v}, q.size() ? q.pop_front() : '1);
      if (sv === 1'b1) chk({37'h0, sd}, dq.size() ? {37'h0, dq.pop_front()} : '1);
      // generated syncs carry the programmed source address; their stamp is free-running
      if (sy === 1'b1) chk({sm[12:0], st}, sq.size() ? sq.pop_front() : {13'hB1, st});
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, sai_pkg::CR_MTU, 32'h0, 1'b0);
      chk({29'h0, rd[15:0]}, {29'h0, sai_pkg::MTU_RST});
      apb(1'b1, 8'hFC, 32'h0, 1'b0);
      chk({e, rd}, {1'b1, 32'h0});
      $display("register test done");
      r = 8'h06 + 8'($unsigned($random(seed)) % 58);
      apb(1'b0, sai_pkg::CR_MAC_LO, 32'hB1, 1'b1);
      apb(1'b0, sai_pkg::CR_SYNC, 32'h8000_0005, 1'b1);
      // not ready yet: disconnect with reason code
      req(32'h0109, 32'h05, {sai_pkg::MSG_CDN, sai_pkg::AVP_RESULT, 10'h00A, 16'h0200});
      // interval 5 lies below the supported range and runs at the minimum
      wt(sy, 1'b1);
      @(posedge pclk);
      wt(sy, 1'b1);
      chk(45'(nw + 1), 45'(sai_pkg::IVAL_MIN) * 45'h4);
      apb(1'b0, sai_pkg::CR_SYNC, 32'h0, 1'b1);
      apb(1'b0, sai_pkg::CR_MAC_LO, 32'h0, 1'b1);
      apb(1'b1, sai_pkg::MR_CTRL, 32'h5, 1'b1);
      apb(1'b1, sai_pkg::MR_MASK_LO, 32'h20, 1'b1);
      req(32'h0209, {r, 8'h05}, {sai_pkg::MSG_ICRP, sai_pkg::AVP_ALLOC_REP, 10'h00C, 16'h0045});
      req(32'h0109, {24'h0, r}, {sai_pkg::MSG_CDN, sai_pkg::AVP_RESULT, 10'h00A, 16'h0203});
      req(32'h0101, 32'h05, {sai_pkg::MSG_ICRP, sai_pkg::AVP_ALLOC_REP, 10'h00C, 16'h0045});
      apb(1'b0, sai_pkg::CR_CTRL, 32'h42, 1'b1);
      wt(sess_up, 1'b1);
      @(posedge pclk);
      r = 8'($random(seed));
      dq.push_back(r);
      tx_valid <= 1'b1;
      tx_data <= r;
      @(posedge pclk);
      tx_valid <= 1'b0;
      apb(1'b1, sai_pkg::MR_TSOFF, 32'h100, 1'b1);
      tsp(32'h0);
      apb(1'b0, sai_pkg::CR_SYNC, 32'h8000_0000, 1'b1);
      apb(1'b0, sai_pkg::CR_CTRL, 32'h04, 1'b1);
      wt(sess_up, 1'b0);
      chk({44'h0, rf_on}, 45'h1);
      chk({44'h0, tx_rdy}, 45'h0);
      tsp(32'h100);
      // data offered after the session is down must not reach the stream
      tx_valid <= 1'b1;
      @(posedge pclk);
      tx_valid <= 1'b0;
      $display("session test done");
      repeat (4) @(posedge pclk);
      chk(45'(q.size() + dq.size() + sq.size()), 45'h0);
      end_sim();
   end
endmodule // session_avp_and_sync_insertion_tb_top
`default_nettype wire
